/* File: inc/sgm_regs.svh */
`ifndef SGM_REGS_SVH
`define SGM_REGS_SVH

// ****************************************************************
// Timing figures and the cycle and tick counts derived from them.
// ****************************************************************
`define SGM_CLK_PERIOD_NS 4
`define SGM_TICK_TIME_US 1000
`define SGM_TICK_CYCLES ((`SGM_TICK_TIME_US * 1000) / `SGM_CLK_PERIOD_NS)
`define SGM_MON_TIME_S 30
`define SGM_MON_TICKS (`SGM_MON_TIME_S * 1000)
`define SGM_AVG_TIME_S 10
`define SGM_AVG_TICKS (`SGM_AVG_TIME_S * 1000)
`define SGM_LOWBAT_TIME_MIN 5
`define SGM_LOWBAT_TICKS (`SGM_LOWBAT_TIME_MIN * 60 * 1000)
`define SGM_FADE_MS 13'h040
`define SGM_IND_UNIT_MS 13'h032
`define SGM_IND_MAX_MS 13'h18ce

// ****************************************************************
// Step limits, step sizes and reset values.
// ****************************************************************
`define SGM_INST_MAX 2'h2
`define SGM_AVG_MAX 5'h12
`define SGM_INST_STEP_DB 7'h03
`define SGM_MEM_A 2'h0

`endif

/* File: inc/sgm_pkg.sv */
package sgm_pkg;

  // Low-supply handling scheme.
  typedef enum logic [1:0] {
    PM_SHALLOW = 2'b00,
    PM_DEEP = 2'b01,
    PM_ADV = 2'b10
  } sgm_pm_mode_e;

  // Power sequencing state.
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_DELAY = 3'b001,
    ST_RUN = 3'b010,
    ST_MUTE = 3'b011
  } sgm_pwr_state_e;

  // The ten fixed indicator events.
  typedef enum logic [3:0] {
    IND_POR = 4'h0, IND_MEM_A = 4'h1, IND_MEM_B = 4'h2, IND_MEM_C = 4'h3, IND_MEM_D = 4'h4,
    IND_VOL_UP = 4'h5, IND_VOL_DN = 4'h6, IND_VOL_MAX = 4'h7, IND_VOL_MIN = 4'h8, IND_LOWBAT = 4'h9
  } sgm_ind_id_e;

  // Supply comparator flags.
  typedef struct packed {
    logic inst_below_lo;
    logic inst_above_mid;
    logic inst_above_hi;
    logic avg_below_lo;
    logic avg_above_hi;
    logic below_deep;
    logic logic_off;
    logic lowbat_below;
  } sgm_supply_s;

  // Gain reduction counts.
  typedef struct packed {
    logic [1:0] inst_steps;
    logic [4:0] avg_steps;
  } sgm_gain_s;

  // Indicator configuration: grouped enables, tone count minus one, tone length in units.
  typedef struct packed {
    logic [6:0] enables;
    logic [1:0] tones_m1;
    logic [6:0] tone_units;
  } sgm_ind_cfg_s;

endpackage

/* File: logic/sgm_sync.sv */
`timescale 1ns/1ps

// ****************************************************************
// Two-stage synchroniser for a vector of independent levels.
// ****************************************************************
module sgm_sync #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule

/* File: logic/sgm_tick.sv */
`timescale 1ns/1ps

// ****************************************************************
// Millisecond tick generator.
// ****************************************************************
module sgm_tick #(
  parameter int CYCLES = 250000
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic tick
);

  logic [19:0] cnt_ff;

  // Counts core clock cycles and pulses once per tick period.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_ff <= 20'h00000;
      tick <= 1'b0;
    end else if (cnt_ff == 20'(CYCLES - 1)) begin
      cnt_ff <= 20'h00000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 20'h00001;
      tick <= 1'b0;
    end
  end

endmodule

/* File: logic/sgm_top.sv */
`timescale 1ns/1ps
`include "sgm_regs.svh"

// ****************************************************************
// Supply-driven power and gain manager.
// ****************************************************************
module sgm_top #(
  parameter int TICK_CYCLES = `SGM_TICK_CYCLES,
  parameter int MON_TICKS = `SGM_MON_TICKS,
  parameter int AVG_TICKS = `SGM_AVG_TICKS,
  parameter int LOWBAT_TICKS = `SGM_LOWBAT_TICKS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire sgm_pkg::sgm_supply_s supply_raw,
  input wire logic [1:0] pm_mode,
  input wire logic [15:0] por_delay_ms,
  input wire sgm_pkg::sgm_ind_cfg_s ind_cfg,
  input wire logic lowbat_en,
  input wire logic mem_req_valid,
  input wire logic [1:0] mem_req,
  input wire logic vol_up_evt,
  input wire logic vol_dn_evt,
  input wire logic vol_max_evt,
  input wire logic vol_min_evt,
  input wire logic prog_active,
  input wire logic prog_sda_drive,
  input wire logic prog_sda_out,
  input wire logic sda_in,
  output logic sda_out_ff,
  output logic sda_oe_ff,
  output logic prog_sda_rx_ff,
  output logic output_en_ff,
  output logic audio_mute_ff,
  output logic fader_mute_ff,
  output logic [1:0] mem_sel_ff,
  output sgm_pkg::sgm_gain_s gain_ff,
  output logic [6:0] gain_db_ff,
  output sgm_pkg::sgm_pwr_state_e state_ff,
  output logic ind_play_ff,
  output sgm_pkg::sgm_ind_id_e ind_id_ff,
  output logic [1:0] ind_tone_ff,
  output logic ind_fade_ff
);

  // Maps an indicator event onto its grouped enable bit.
  function automatic logic ind_enabled(input sgm_pkg::sgm_ind_id_e id, input logic [6:0] en);
    case (id)
      sgm_pkg::IND_POR: ind_enabled = en[0];
      sgm_pkg::IND_MEM_A: ind_enabled = en[1];
      sgm_pkg::IND_MEM_B: ind_enabled = en[2];
      sgm_pkg::IND_MEM_C: ind_enabled = en[3];
      sgm_pkg::IND_MEM_D: ind_enabled = en[4];
      sgm_pkg::IND_VOL_UP, sgm_pkg::IND_VOL_DN: ind_enabled = en[5];
      sgm_pkg::IND_VOL_MAX, sgm_pkg::IND_VOL_MIN: ind_enabled = en[6];
      default: ind_enabled = en[6] ? 1'b0 : 1'b0;
    endcase
  endfunction

  sgm_pkg::sgm_supply_s f;
  sgm_pkg::sgm_pwr_state_e nxt_state;
  sgm_pkg::sgm_ind_id_e nxt_ind_id;
  logic tick, cold_ff, deep_seen_ff, por_evt_ff, mem_evt_ff, lb_evt_ff, lb_first_ff;
  logic adv_run, hold_ff, hi_ok_ff, mid_ok_ff, adv_mute_ff, lb_active, nxt_ind_go;
  logic [15:0] dly_cnt_ff;
  logic [14:0] mon_cnt_ff;
  logic [13:0] avg_cnt_ff;
  logic [18:0] lb_cnt_ff;
  logic [12:0] ind_ms_ff, ind_tot_ff, tone_ms, nxt_ms;

  // ****************************************************************
  // Input synchronisation and the millisecond time base.
  // ****************************************************************
  sgm_sync #(.W($bits(sgm_pkg::sgm_supply_s))) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .din(supply_raw),
    .dout(f)
  );

  sgm_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick)
  );

  // ****************************************************************
  // Power sequencing.
  // ****************************************************************
  // Next state from supply flags and the selected scheme.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sgm_pkg::ST_OFF: begin
        if (!f.logic_off && f.inst_above_hi) begin
          if (cold_ff || deep_seen_ff || f.below_deep) begin
            nxt_state = sgm_pkg::ST_DELAY;
          end else if (pm_mode != sgm_pkg::PM_DEEP) begin
            nxt_state = sgm_pkg::ST_RUN;
          end
        end
      end
      sgm_pkg::ST_DELAY: begin
        if (dly_cnt_ff >= por_delay_ms) begin
          nxt_state = sgm_pkg::ST_RUN;
        end
      end
      sgm_pkg::ST_RUN: begin
        if (pm_mode != sgm_pkg::PM_ADV && f.inst_below_lo) begin
          nxt_state = sgm_pkg::ST_MUTE;
        end
      end
      sgm_pkg::ST_MUTE: begin
        if (pm_mode != sgm_pkg::PM_DEEP && (f.inst_above_hi || pm_mode == sgm_pkg::PM_ADV)) begin
          nxt_state = sgm_pkg::ST_RUN;
        end
      end
      default: nxt_state = sgm_pkg::ST_OFF;
    endcase
    if (f.logic_off) begin
      nxt_state = sgm_pkg::ST_OFF;
    end
  end

  // State register, deep-dip memory and memory selection.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= sgm_pkg::ST_OFF;
      cold_ff <= 1'b1;
      deep_seen_ff <= 1'b0;
      mem_sel_ff <= `SGM_MEM_A;
      por_evt_ff <= 1'b0;
      mem_evt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      por_evt_ff <= state_ff == sgm_pkg::ST_DELAY && nxt_state == sgm_pkg::ST_RUN;
      mem_evt_ff <= 1'b0;
      if (state_ff == sgm_pkg::ST_OFF && f.below_deep) begin
        deep_seen_ff <= 1'b1;
      end
      if (state_ff == sgm_pkg::ST_OFF && nxt_state != sgm_pkg::ST_OFF) begin
        cold_ff <= 1'b0;
        deep_seen_ff <= 1'b0;
        if (nxt_state == sgm_pkg::ST_DELAY) begin
          mem_sel_ff <= `SGM_MEM_A;
        end
      end else if (mem_req_valid && (state_ff == sgm_pkg::ST_RUN || state_ff == sgm_pkg::ST_MUTE)) begin
        mem_sel_ff <= mem_req;
        mem_evt_ff <= 1'b1;
      end
    end
  end

  // Power-on delay counter, counting only while the delay runs.
  always_ff @(posedge core_clk) begin
    if (reset || state_ff != sgm_pkg::ST_DELAY) begin
      dly_cnt_ff <= 16'h0000;
    end else if (tick && dly_cnt_ff != 16'hffff) begin
      dly_cnt_ff <= dly_cnt_ff + 16'h0001;
    end
  end

  // ****************************************************************
  // Advanced gain management.
  // ****************************************************************
  assign adv_run = state_ff == sgm_pkg::ST_RUN && pm_mode == sgm_pkg::PM_ADV;

  // Instantaneous steps with stabilisation and monitoring periods.
  always_ff @(posedge core_clk) begin
    if (reset || !adv_run) begin
      gain_ff.inst_steps <= 2'h0;
      hold_ff <= 1'b0;
      hi_ok_ff <= 1'b1;
      mid_ok_ff <= 1'b1;
      mon_cnt_ff <= 15'h0000;
    end else if (!hold_ff && f.inst_below_lo && !f.avg_below_lo && gain_ff.inst_steps != `SGM_INST_MAX) begin
      gain_ff.inst_steps <= gain_ff.inst_steps + 2'h1;
      hold_ff <= 1'b1;
      mon_cnt_ff <= 15'h0000;
    end else if (tick && mon_cnt_ff == 15'(MON_TICKS - 1)) begin
      mon_cnt_ff <= 15'h0000;
      hold_ff <= 1'b0;
      hi_ok_ff <= 1'b1;
      mid_ok_ff <= 1'b1;
      if (!hold_ff && hi_ok_ff && f.inst_above_hi) begin
        gain_ff.inst_steps <= 2'h0;
      end else if (!hold_ff && mid_ok_ff && f.inst_above_mid && gain_ff.inst_steps == `SGM_INST_MAX) begin
        gain_ff.inst_steps <= 2'h1;
      end
    end else begin
      if (tick) begin
        mon_cnt_ff <= mon_cnt_ff + 15'h0001;
      end
      if (!f.inst_above_hi) begin
        hi_ok_ff <= 1'b0;
      end
      if (!f.inst_above_mid) begin
        mid_ok_ff <= 1'b0;
      end
    end
  end

  // Average steps once per interval, with mute at the limit.
  always_ff @(posedge core_clk) begin
    if (reset || !adv_run) begin
      gain_ff.avg_steps <= 5'h00;
      adv_mute_ff <= 1'b0;
      avg_cnt_ff <= 14'h0000;
    end else begin
      if (f.avg_above_hi) begin
        adv_mute_ff <= 1'b0;
      end
      if (tick) begin
        avg_cnt_ff <= (avg_cnt_ff == 14'(AVG_TICKS - 1)) ? 14'h0000 : avg_cnt_ff + 14'h0001;
      end
      if (tick && avg_cnt_ff == 14'(AVG_TICKS - 1)) begin
        if (f.avg_below_lo && gain_ff.avg_steps != `SGM_AVG_MAX) begin
          gain_ff.avg_steps <= gain_ff.avg_steps + 5'h01;
          if (gain_ff.avg_steps == `SGM_AVG_MAX - 5'h01) begin
            adv_mute_ff <= 1'b1;
          end
        end else if (f.avg_above_hi && !adv_mute_ff && gain_ff.avg_steps != 5'h00) begin
          gain_ff.avg_steps <= gain_ff.avg_steps - 5'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Low-battery repeat timer.
  // ****************************************************************
  assign lb_active = lowbat_en && f.lowbat_below && (state_ff == sgm_pkg::ST_RUN || state_ff == sgm_pkg::ST_MUTE);

  // First notice at once, then one per repeat period until shutdown.
  always_ff @(posedge core_clk) begin
    if (reset || !lb_active) begin
      lb_cnt_ff <= 19'h00000;
      lb_first_ff <= 1'b1;
      lb_evt_ff <= 1'b0;
    end else begin
      lb_first_ff <= 1'b0;
      lb_evt_ff <= lb_first_ff || (tick && lb_cnt_ff == 19'(LOWBAT_TICKS - 1));
      if (tick) begin
        lb_cnt_ff <= (lb_cnt_ff == 19'(LOWBAT_TICKS - 1)) ? 19'h00000 : lb_cnt_ff + 19'h00001;
      end
    end
  end

  // ****************************************************************
  // Indicator player.
  // ****************************************************************
  // Picks the highest-priority event; events arriving during playback are dropped.
  always_comb begin
    nxt_ind_id = sgm_pkg::IND_POR;
    nxt_ind_go = 1'b0;
    if (por_evt_ff) begin
      nxt_ind_id = sgm_pkg::IND_POR;
      nxt_ind_go = ind_enabled(sgm_pkg::IND_POR, ind_cfg.enables);
    end else if (lb_evt_ff) begin
      nxt_ind_id = sgm_pkg::IND_LOWBAT;
      nxt_ind_go = 1'b1;
    end else if (mem_evt_ff) begin
      nxt_ind_id = sgm_pkg::sgm_ind_id_e'({2'h0, mem_sel_ff} + 4'h1);
      nxt_ind_go = ind_enabled(nxt_ind_id, ind_cfg.enables);
    end else if (state_ff == sgm_pkg::ST_RUN && (vol_up_evt || vol_dn_evt || vol_max_evt || vol_min_evt)) begin
      nxt_ind_id = vol_max_evt ? sgm_pkg::IND_VOL_MAX : vol_min_evt ? sgm_pkg::IND_VOL_MIN :
                   vol_up_evt ? sgm_pkg::IND_VOL_UP : sgm_pkg::IND_VOL_DN;
      nxt_ind_go = ind_enabled(nxt_ind_id, ind_cfg.enables);
    end
  end

  assign tone_ms = (ind_cfg.tone_units == 7'h00) ? `SGM_IND_UNIT_MS : 13'(ind_cfg.tone_units * `SGM_IND_UNIT_MS);
  assign nxt_ms = (ind_ms_ff + 13'h0001 >= tone_ms) ? 13'h0000 : ind_ms_ff + 13'h0001;

  // Steps through tones and fades, ending at the tone count or the duration cap.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ind_play_ff <= 1'b0;
      ind_id_ff <= sgm_pkg::IND_POR;
      ind_tone_ff <= 2'h0;
      ind_ms_ff <= 13'h0000;
      ind_tot_ff <= 13'h0000;
      ind_fade_ff <= 1'b0;
    end else if (!ind_play_ff) begin
      if (nxt_ind_go) begin
        ind_play_ff <= 1'b1;
        ind_id_ff <= nxt_ind_id;
        ind_fade_ff <= 1'b1;
      end
      ind_tone_ff <= 2'h0;
      ind_ms_ff <= 13'h0000;
      ind_tot_ff <= 13'h0000;
    end else if (tick) begin
      ind_ms_ff <= nxt_ms;
      ind_tot_ff <= ind_tot_ff + 13'h0001;
      ind_fade_ff <= (nxt_ms < `SGM_FADE_MS) || (nxt_ms + `SGM_FADE_MS >= tone_ms);
      if (ind_tot_ff + 13'h0001 >= `SGM_IND_MAX_MS) begin
        ind_play_ff <= 1'b0;
      end else if (nxt_ms == 13'h0000) begin
        if (ind_tone_ff == ind_cfg.tones_m1) begin
          ind_play_ff <= 1'b0;
        end else begin
          ind_tone_ff <= ind_tone_ff + 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Audio path controls and programming pin.
  // ****************************************************************
  // Output enable, low-supply mute, programming fader mute and total gain.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_en_ff <= 1'b0;
      audio_mute_ff <= 1'b1;
      fader_mute_ff <= 1'b0;
      gain_db_ff <= 7'h00;
    end else begin
      output_en_ff <= state_ff == sgm_pkg::ST_RUN || state_ff == sgm_pkg::ST_MUTE;
      audio_mute_ff <= state_ff != sgm_pkg::ST_RUN || adv_mute_ff;
      fader_mute_ff <= prog_active;
      gain_db_ff <= 7'(gain_ff.inst_steps * `SGM_INST_STEP_DB) + {2'h0, gain_ff.avg_steps};
    end
  end

  // The data pin is driven only while the programming engine holds its turn.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      prog_sda_rx_ff <= 1'b1;
    end else begin
      sda_out_ff <= prog_sda_out;
      sda_oe_ff <= prog_sda_drive;
      prog_sda_rx_ff <= sda_in;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  out_after_delay_a: assert property (output_en_ff |-> $past(state_ff) inside {sgm_pkg::ST_RUN, sgm_pkg::ST_MUTE}) else $error("output on outside run");
  press_ignored_a: assert property (state_ff == sgm_pkg::ST_DELAY && mem_req_valid |=> $stable(mem_sel_ff)) else $error("press in delay");
  shallow_mute_a: assert property (state_ff == sgm_pkg::ST_RUN && pm_mode == sgm_pkg::PM_SHALLOW && f.inst_below_lo && !f.logic_off |=> state_ff == sgm_pkg::ST_MUTE ##1 audio_mute_ff) else $error("no shallow mute");
  deep_hold_a: assert property (state_ff == sgm_pkg::ST_MUTE && pm_mode == sgm_pkg::PM_DEEP && !f.logic_off |=> state_ff == sgm_pkg::ST_MUTE) else $error("deep mute left");
  reinit_mem_a: assert property ($past(state_ff) == sgm_pkg::ST_OFF && state_ff == sgm_pkg::ST_DELAY |-> mem_sel_ff == `SGM_MEM_A) else $error("reinit not mem A");
  inst_hold_a: assert property (adv_run && gain_ff.inst_steps != 2'h0 && $changed(gain_ff.inst_steps) && $past(gain_ff.inst_steps) < gain_ff.inst_steps |-> hold_ff && mon_cnt_ff == 15'h0000) else $error("no stabilisation");
  inst_limit_a: assert property (gain_ff.inst_steps <= `SGM_INST_MAX) else $error("too many inst steps");
  avg_mute_a: assert property (adv_run && $rose(gain_ff.avg_steps == `SGM_AVG_MAX) |-> adv_mute_ff ##1 audio_mute_ff) else $error("no mute at max");
  avg_steady_a: assert property ((adv_run && !f.avg_below_lo && !f.avg_above_hi) ##1 adv_run |-> $stable(gain_ff.avg_steps)) else $error("avg moved mid band");
  fader_a: assert property (prog_active |=> fader_mute_ff) else $error("no fader mute");
  ind_cap_a: assert property (ind_tot_ff < `SGM_IND_MAX_MS) else $error("indicator too long");

  two_steps_c: cover property (adv_run && gain_ff.inst_steps == `SGM_INST_MAX);
  avg_muted_c: cover property (adv_run && adv_mute_ff);
  resume_c: cover property (state_ff == sgm_pkg::ST_OFF ##1 state_ff == sgm_pkg::ST_RUN);
  lowbat_c: cover property (ind_play_ff && ind_id_ff == sgm_pkg::IND_LOWBAT);

endmodule

/* File: verification/sgm_supply_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// Battery comparators and the pulled-up data pin.
// ****************************************************************
module sgm_supply_model (
  input wire logic [11:0] inst_mv,
  input wire logic [11:0] avg_mv,
  input wire logic [11:0] lowbat_mv,
  input wire logic hw_off,
  input wire logic sda_oe,
  input wire logic sda_out,
  output sgm_pkg::sgm_supply_s flags,
  output logic sda_line
);
  // Levels are in millivolts; all but two flags trip against fixed points: lowbat_below against lowbat_mv, logic_off straight from hw_off.
  always_comb begin
    flags.inst_below_lo = inst_mv < 12'h3b6;
    flags.inst_above_mid = inst_mv > 12'h3e8;
    flags.inst_above_hi = inst_mv > 12'h44c;
    flags.avg_below_lo = avg_mv < 12'h3b6;
    flags.avg_above_hi = avg_mv > 12'h44c;
    flags.below_deep = inst_mv < 12'h258;
    flags.logic_off = hw_off;
    flags.lowbat_below = inst_mv < lowbat_mv;
  end
  // The device drives the pin in its turn; released, the pin floats up.
  assign sda_line = sda_oe ? sda_out : 1'b1;
endmodule

/* File: verification/supply_gain_manager_bench.sv */
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the supply gain manager.
// ****************************************************************
module supply_gain_manager_bench;
  localparam int ST = 0, OE = 1, MU = 2, IS = 3, AS = 4, FM = 5, IP = 6, MS = 7, II = 8, GD = 9, RX = 10;
  localparam int SO = 11, TN = 12, FD = 13;
  logic core_clk, reset, hw_off, lowbat_en, mem_req_valid, vol_up_evt, prog_active, prog_sda_drive, prog_sda_out;
  logic sda_in, sda_out_ff, sda_oe_ff, output_en_ff, audio_mute_ff, fader_mute_ff, ind_play_ff;
  logic vol_dn_evt, vol_max_evt, prog_sda_rx_ff, ind_fade_ff;
  logic [6:0] gain_db_ff;
  logic [11:0] inst_mv, avg_mv, lowbat_mv;
  logic [1:0] pm_mode, mem_req, m, mem_sel_ff, ind_tone_ff;
  sgm_pkg::sgm_ind_cfg_s ind_cfg;
  logic [15:0] por_delay_ms;
  sgm_pkg::sgm_supply_s supply_raw;
  sgm_pkg::sgm_gain_s gain_ff;
  sgm_pkg::sgm_pwr_state_e state_ff;
  sgm_pkg::sgm_ind_id_e ind_id_ff;
  int n_fail = 0, checks = 0, seed = 7120, cyc = 0, dly;
  int id_q[$];
  logic [7:0] exp_q[$];
  string nm[14] = '{"state", "output_en", "audio_mute", "inst", "avg", "fader", "ind_play", "mem_sel", "ind_id",
    "gain_db", "sda_rx", "sda_oe", "ind_tone", "ind_fade"};
  event smp;

  sgm_supply_model model (.inst_mv(inst_mv), .avg_mv(avg_mv), .lowbat_mv(lowbat_mv), .hw_off(hw_off),
    .sda_oe(sda_oe_ff), .sda_out(sda_out_ff), .flags(supply_raw), .sda_line(sda_in));
  sgm_top #(.TICK_CYCLES(10), .MON_TICKS(20), .AVG_TICKS(8), .LOWBAT_TICKS(80)) dut (
    .core_clk(core_clk), .reset(reset), .supply_raw(supply_raw), .pm_mode(pm_mode), .por_delay_ms(por_delay_ms),
    .ind_cfg(ind_cfg), .lowbat_en(lowbat_en), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
    .vol_up_evt(vol_up_evt), .vol_dn_evt(vol_dn_evt), .vol_max_evt(vol_max_evt), .vol_min_evt(1'b0),
    .prog_active(prog_active), .prog_sda_drive(prog_sda_drive), .prog_sda_out(prog_sda_out), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .prog_sda_rx_ff(prog_sda_rx_ff), .output_en_ff(output_en_ff),
    .audio_mute_ff(audio_mute_ff), .fader_mute_ff(fader_mute_ff), .mem_sel_ff(mem_sel_ff), .gain_ff(gain_ff),
    .gain_db_ff(gain_db_ff), .state_ff(state_ff), .ind_play_ff(ind_play_ff), .ind_id_ff(ind_id_ff),
    .ind_tone_ff(ind_tone_ff), .ind_fade_ff(ind_fade_ff));

  // Clock of 4 ns period.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ex(input int id, input logic [7:0] v);
    id_q.push_back(id);
    exp_q.push_back(v);
    -> smp;
  endtask
  task automatic sup(input logic [11:0] i, input logic [11:0] a, input logic off, input int n);
    @(posedge core_clk);
    inst_mv <= i;
    avg_mv <= a;
    hw_off <= off;
    cyc_n(n);
  endtask
  task automatic mem_set();
    m = 2'h1 + 2'($unsigned($random(seed)) % 3);
    @(posedge core_clk);
    mem_req_valid <= 1'b1;
    mem_req <= m;
    @(posedge core_clk);
    mem_req_valid <= 1'b0;
    cyc_n(3);
    ex(MS, 8'(m));
  endtask

  // Whenever a result is flagged, takes every queued note, oldest first, and compares it.
  initial begin
    int id;
    logic [7:0] seen;
    forever begin
      @(smp);
      while (id_q.size() > 0) begin
        id = id_q.pop_front();
        case (id)
          ST: seen = 8'(state_ff);
          OE: seen = {7'h00, output_en_ff};
          MU: seen = {7'h00, audio_mute_ff};
          IS: seen = {6'h00, gain_ff.inst_steps};
          AS: seen = {3'h0, gain_ff.avg_steps};
          FM: seen = {7'h00, fader_mute_ff};
          IP: seen = {7'h00, ind_play_ff};
          MS: seen = {6'h00, mem_sel_ff};
          GD: seen = {1'b0, gain_db_ff};
          RX: seen = {7'h00, prog_sda_rx_ff};
          SO: seen = {7'h00, sda_oe_ff};
          TN: seen = {6'h00, ind_tone_ff};
          FD: seen = {7'h00, ind_fade_ff};
          default: seen = 8'(ind_id_ff);
        endcase
        compare(nm[id], seen, exp_q.pop_front());
      end
    end
  end

  // Cuts a hang short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    reset = 1'b1; hw_off = 1'b1; inst_mv = 12'h000; avg_mv = 12'h4b0; lowbat_mv = 12'h000; pm_mode = 2'h0;
    lowbat_en = 1'b0; mem_req_valid = 1'b0; mem_req = 2'h0; vol_up_evt = 1'b0; prog_active = 1'b0;
    prog_sda_drive = 1'b0; prog_sda_out = 1'b0;
    vol_dn_evt = 1'b0;
    vol_max_evt = 1'b0;
    ind_cfg = {7'h7f, 2'h0, 7'h00};
    por_delay_ms = 16'h0002 + 16'($unsigned($random(seed)) % 4);
    dly = (int'(por_delay_ms) + 2) * 10;
    cyc_n(12);
    ex(ST, 8'(sgm_pkg::ST_OFF)); ex(OE, 8'h00); ex(MU, 8'h01); ex(MS, 8'h00); ex(IS, 8'h00); ex(IP, 8'h00);
    @(posedge core_clk) reset <= 1'b0;
    sup(12'h4b0, 12'h4b0, 1'b0, 5);
    ex(ST, 8'(sgm_pkg::ST_DELAY)); ex(OE, 8'h00);
    @(posedge core_clk) vol_up_evt <= 1'b1;
    mem_req_valid <= 1'b1;
    mem_req <= 2'h3;
    @(posedge core_clk) vol_up_evt <= 1'b0;
    mem_req_valid <= 1'b0;
    cyc_n(3);
    ex(IP, 8'h00); ex(MS, 8'h00);
    cyc_n(dly);
    ex(ST, 8'(sgm_pkg::ST_RUN)); ex(OE, 8'h01); ex(IP, 8'h01); ex(II, 8'(sgm_pkg::IND_POR));
    $display("test power_on done");
    mem_set();
    sup(12'h384, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_MUTE)); ex(MU, 8'h01);
    sup(12'h41a, 12'h4b0, 1'b0, 20);
    ex(ST, 8'(sgm_pkg::ST_MUTE));
    sup(12'h4b0, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_RUN)); ex(MU, 8'h00);
    sup(12'h2bc, 12'h4b0, 1'b1, 6);
    ex(ST, 8'(sgm_pkg::ST_OFF)); ex(OE, 8'h00);
    sup(12'h4b0, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_RUN)); ex(MS, 8'(m));
    sup(12'h1f4, 12'h4b0, 1'b1, 6);
    sup(12'h4b0, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_DELAY)); ex(MS, 8'h00);
    cyc_n(dly);
    ex(ST, 8'(sgm_pkg::ST_RUN)); ex(OE, 8'h01);
    $display("test shallow done");
    @(posedge core_clk) pm_mode <= 2'h1;
    mem_set();
    sup(12'h384, 12'h4b0, 1'b0, 6);
    sup(12'h4b0, 12'h4b0, 1'b0, 20);
    ex(ST, 8'(sgm_pkg::ST_MUTE)); ex(MU, 8'h01);
    sup(12'h1f4, 12'h4b0, 1'b1, 6);
    sup(12'h4b0, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_DELAY)); ex(MS, 8'h00);
    cyc_n(dly);
    ex(ST, 8'(sgm_pkg::ST_RUN));
    $display("test deep done");
    @(posedge core_clk) pm_mode <= 2'h2;
    mem_set();
    sup(12'h384, 12'h4b0, 1'b0, 2);
    sup(12'h41a, 12'h4b0, 1'b0, 6);
    ex(IS, 8'h01); ex(ST, 8'(sgm_pkg::ST_RUN));
    sup(12'h384, 12'h4b0, 1'b0, 2);
    sup(12'h41a, 12'h4b0, 1'b0, 220);
    ex(IS, 8'h01);
    sup(12'h384, 12'h4b0, 1'b0, 2);
    sup(12'h41a, 12'h4b0, 1'b0, 220);
    ex(IS, 8'h02); ex(GD, 8'h06);
    sup(12'h384, 12'h4b0, 1'b0, 2);
    sup(12'h41a, 12'h4b0, 1'b0, 620);
    ex(IS, 8'h01);
    sup(12'h41a, 12'h384, 1'b0, 1500);
    ex(AS, 8'h12); ex(MU, 8'h01); ex(IS, 8'h01); ex(GD, 8'h15);
    sup(12'h41a, 12'h3e8, 1'b0, 200);
    ex(AS, 8'h12);
    sup(12'h41a, 12'h4b0, 1'b0, 5);
    ex(MU, 8'h00);
    cyc_n(1500);
    ex(AS, 8'h00); ex(IS, 8'h01);
    sup(12'h4b0, 12'h4b0, 1'b0, 420);
    ex(IS, 8'h00);
    sup(12'h2bc, 12'h4b0, 1'b1, 6);
    sup(12'h4b0, 12'h4b0, 1'b0, 6);
    ex(ST, 8'(sgm_pkg::ST_RUN)); ex(MS, 8'(m));
    $display("test advanced done");
    @(posedge core_clk) lowbat_en <= 1'b1;
    lowbat_mv <= 12'h514;
    cyc_n(8);
    ex(IP, 8'h01); ex(II, 8'(sgm_pkg::IND_LOWBAT));
    ex(FD, 8'h01);
    cyc_n(600);
    ex(IP, 8'h00);
    cyc_n(250);
    ex(IP, 8'h01);
    @(posedge core_clk) prog_active <= 1'b1;
    m = 2'($random(seed));
    prog_sda_drive <= m[0];
    prog_sda_out <= m[1];
    cyc_n(3);
    ex(FM, 8'h01); ex(SO, 8'(m[0])); ex(RX, 8'(m[0] ? m[1] : 1'b1));
    @(posedge core_clk) prog_active <= 1'b0;
    lowbat_en <= 1'b0;
    cyc_n(3);
    ex(FM, 8'h00);
    $display("test lowbat_prog done");
    cyc_n(600);
    ex(IP, 8'h00);
    @(posedge core_clk) ind_cfg <= {7'h3f, 2'h1, 7'h01};
    vol_max_evt <= 1'b1;
    @(posedge core_clk) vol_max_evt <= 1'b0;
    cyc_n(3);
    ex(IP, 8'h00);
    @(posedge core_clk) vol_dn_evt <= 1'b1;
    @(posedge core_clk) vol_dn_evt <= 1'b0;
    cyc_n(3);
    ex(IP, 8'h01); ex(II, 8'(sgm_pkg::IND_VOL_DN)); ex(TN, 8'h00);
    cyc_n(700);
    ex(IP, 8'h01); ex(TN, 8'h01);
    cyc_n(400);
    ex(IP, 8'h00);
    $display("test volume done");
    cyc_n(2);
    end_of_test();
  end
endmodule
